/* haptic_channel_sequencer.sv */
// demonstration sequencer for eight haptic drivers behind a channel switch
// What this block does
// - each button press while idle steps to next of five modes, wrapping around
// - mode one enables all eight drivers and connects all channels
// - modes two/three enable group, send ERM or LRA init, play magnitude 0x7F
// - modes two/three play two seconds, then internal trigger stops it
// - modes four/five play each driver in turn for 500 ms
// - then 100 ms off, then 100 ms pulse on all four drivers
// - after reset buttons are live and USB command mode is off
// - user switch enters USB mode, lights LED, buttons then ignored
// - USB mode is left only by reset
// - expander outputs drive the driver enables, one port per driver
// - direction register 0x03, a zero bit makes that port an output
// - register 0x01 sets each output port level bit by bit
// - expander output levels start at zero, drivers start disabled
// - switch takes a single selection byte, any channel combination
// - switch keeps the last byte; no register byte is sent, the reg field repeats the value
module haptic_channel_sequencer
  import haptic_seq_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic i_core_clk,            // 100 MHz system clock
  input wire logic i_rst,                 // synchronous reset, high
  input wire logic i_second_touch_button, // touch button pin, high pressed
  input wire logic i_usb_entry_switch,    // user switch pin, high pressed
  input wire logic i_i2c_done,            // i2c master finished a write
  output logic o_i2c_req,                 // write request to i2c master
  output logic [6:0] o_i2c_addr,          // 7-bit slave address
  output logic o_i2c_has_reg,             // register byte is sent
  output logic [7:0] o_i2c_reg,           // register byte
  output logic [7:0] o_i2c_data,          // data byte
  output logic o_usb_mode_indicator,      // led, high in usb mode
  output logic o_touch_enabled,           // buttons are accepted
  output logic o_busy,                    // a sequence is running
  output logic [2:0] o_mode               // current demonstration mode
);
  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ms_timer_if tif ();
  logic btn_s1_q, btn_s2_q, btn_s3_q;
  logic usw_s1_q, usw_s2_q, usw_s3_q;
  logic btn_press, usw_press, press_acc, adv;
  seq_state_t state_q, state_d, wnext_q, wnext_d;
  logic [2:0] mode_q, mode_d;
  logic [1:0] idx_q, idx_d;
  logic pulse_q, pulse_d;
  logic usb_q, usb_d;
  logic req_q, req_d, has_reg_q, has_reg_d;
  logic [6:0] addr_q, addr_d;
  logic [7:0] reg_q, reg_d, data_q, data_d;
  logic busy_q, busy_d;
  logic touch_q, touch_d;
  logic seq_mode, lra_mode;
  logic [7:0] grp, chan;
  logic [MS_W-1:0] ld_ms;
  logic ld;

  // ----------------------------------------------------------------------
  // pin synchronisers and press edges
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
      usw_s1_q <= 1'b0;
      usw_s2_q <= 1'b0;
      usw_s3_q <= 1'b0;
    end else begin
      btn_s1_q <= i_second_touch_button;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
      usw_s1_q <= i_usb_entry_switch;
      usw_s2_q <= usw_s1_q;
      usw_s3_q <= usw_s2_q;
    end
  end

  assign btn_press = btn_s2_q && !btn_s3_q;
  assign usw_press = usw_s2_q && !usw_s3_q;
  // buttons count only when live and no sequence runs
  assign press_acc = btn_press && !usb_q && state_q == S_IDLE;
  assign adv = req_q && i_i2c_done;

  // ----------------------------------------------------------------------
  // mode decode: driver group, single channel, actuator kind
  // ----------------------------------------------------------------------
  assign seq_mode = (mode_q == M_ERM_SEQ) || (mode_q == M_LRA_SEQ);
  assign lra_mode = (mode_q == M_LRA_SIM) || (mode_q == M_LRA_SEQ);
  always_comb begin
    unique case (mode_q)
      M_ALL: grp = GRP_ALL;
      M_ERM_SIM, M_ERM_SEQ: grp = GRP_ERM;
      default: grp = GRP_LRA;
    endcase
  end
  // one selection bit per channel, within the group
  assign chan = 8'h01 << {lra_mode, idx_q};

  // ----------------------------------------------------------------------
  // sequence state machine and mode stepping
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    wnext_d = wnext_q;
    mode_d = mode_q;
    idx_d = idx_q;
    pulse_d = pulse_q;
    ld = 1'b0;
    ld_ms = PLAY_LONG_MS;
    unique case (state_q)
      S_BOOT: if (adv) state_d = S_IDLE;
      S_IDLE: begin
        if (press_acc) begin
          // five modes in fixed order, wrapping
          mode_d = (mode_q == M_LRA_SEQ) ? M_ALL : mode_q + 3'h1;
          idx_d = 2'h0;
          pulse_d = 1'b0;
          state_d = S_DIR;
        end
      end
      S_DIR: if (adv) state_d = S_OUT;
      S_OUT: if (adv) state_d = S_SW;
      S_SW: begin
        if (adv) begin
          state_d = (mode_q == M_ALL) ? S_IDLE : S_INIT;
        end
      end
      S_INIT: if (adv) state_d = S_RTPV;
      S_RTPV: if (adv) state_d = seq_mode ? S_CHAN : S_RTPM;
      S_CHAN: if (adv) state_d = S_RTPM;
      S_RTPM: begin
        if (adv) begin
          ld = 1'b1;
          if (!seq_mode) begin
            ld_ms = PLAY_LONG_MS;
          end else if (pulse_q) begin
            ld_ms = PULSE_MS;
          end else begin
            ld_ms = STEP_MS;
          end
          wnext_d = S_STOP;
          state_d = S_WAIT;
        end
      end
      S_WAIT: if (tif.done) state_d = wnext_q;
      S_STOP: begin
        if (adv) begin
          if (!seq_mode || pulse_q) begin
            state_d = S_IDLE;
          end else if (idx_q != LAST_IDX) begin
            idx_d = idx_q + 2'h1;
            state_d = S_CHAN;
          end else begin
            state_d = S_GROUP;
          end
        end
      end
      S_GROUP: begin
        if (adv) begin
          // all four connected and out of playback for the gap
          ld = 1'b1;
          ld_ms = PULSE_MS;
          pulse_d = 1'b1;
          wnext_d = S_RTPM;
          state_d = S_WAIT;
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  assign tif.load = ld;
  assign tif.ms = ld_ms;

  // ----------------------------------------------------------------------
  // usb command mode: entered by switch, left only by reset
  // ----------------------------------------------------------------------
  always_comb begin
    usb_d = usb_q || usw_press;
    touch_d = !usb_d;
    busy_d = (state_d != S_IDLE);
  end

  // ----------------------------------------------------------------------
  // write command for the i2c master, held until it is done
  // ----------------------------------------------------------------------
  always_comb begin
    req_d = 1'b1;
    addr_d = DRV_ADDR;
    has_reg_d = 1'b1;
    reg_d = DRV_REG_MODE;
    data_d = DRV_MODE_RTP;
    unique case (state_q)
      S_BOOT: begin
        addr_d = EXP_ADDR;
        reg_d = EXP_REG_OUT;
        data_d = EXP_OUT_RESET;
      end
      S_DIR: begin
        addr_d = EXP_ADDR;
        reg_d = EXP_REG_DIR;
        data_d = ~grp;
      end
      S_OUT: begin
        addr_d = EXP_ADDR;
        reg_d = EXP_REG_OUT;
        data_d = grp;
      end
      S_SW, S_GROUP: begin
        addr_d = SW_ADDR;
        has_reg_d = 1'b0;
        reg_d = grp;
        data_d = grp;
      end
      S_CHAN: begin
        addr_d = SW_ADDR;
        has_reg_d = 1'b0;
        reg_d = chan;
        data_d = chan;
      end
      S_INIT: begin
        reg_d = DRV_REG_FB;
        data_d = lra_mode ? FB_LRA : FB_ERM;
      end
      S_RTPV: begin
        reg_d = DRV_REG_RTP;
        data_d = RTP_MAG;
      end
      S_RTPM: data_d = DRV_MODE_RTP;
      S_STOP: data_d = DRV_MODE_INT_TRIG;
      default: req_d = 1'b0;
    endcase
    if (adv || !req_d || (state_q != state_d)) begin
      req_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_q <= S_BOOT;
      wnext_q <= S_IDLE;
      mode_q <= MODE_RESET;
      idx_q <= 2'h0;
      pulse_q <= 1'b0;
      usb_q <= 1'b0;
      touch_q <= 1'b1;
      busy_q <= 1'b1;
      req_q <= 1'b0;
      addr_q <= 7'h00;
      has_reg_q <= 1'b0;
      reg_q <= 8'h00;
      data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      wnext_q <= wnext_d;
      mode_q <= mode_d;
      idx_q <= idx_d;
      pulse_q <= pulse_d;
      usb_q <= usb_d;
      touch_q <= touch_d;
      busy_q <= busy_d;
      req_q <= req_d;
      addr_q <= addr_d;
      has_reg_q <= has_reg_d;
      reg_q <= reg_d;
      data_q <= data_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign o_i2c_req = req_q;
  assign o_i2c_addr = addr_q;
  assign o_i2c_has_reg = has_reg_q;
  assign o_i2c_reg = reg_q;
  assign o_i2c_data = data_q;
  assign o_usb_mode_indicator = usb_q;
  assign o_touch_enabled = touch_q;
  assign o_busy = busy_q;
  assign o_mode = mode_q;

  // millisecond timer for playback lengths
  ms_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .tif(tif)
  );

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  mode_step_a: assert property (press_acc |=> mode_q ==
      (($past(mode_q) == M_LRA_SEQ) ? M_ALL : $past(mode_q) + 3'h1))
    else $error("mode did not step in order");
  all_enable_a: assert property (req_q && state_q == S_OUT &&
      mode_q == M_ALL |-> addr_q == EXP_ADDR && data_q == 8'hff)
    else $error("mode one does not enable every driver");
  rtp_mag_a: assert property (req_q && state_q == S_RTPV |->
      reg_q == DRV_REG_RTP && data_q == RTP_MAG)
    else $error("playback magnitude wrong");
  long_play_a: assert property (state_q == S_RTPM && adv && !seq_mode |->
      tif.load && tif.ms == 11'h7d0)
    else $error("simultaneous playback is not two seconds");
  step_play_a: assert property (state_q == S_RTPM && adv && seq_mode &&
      !pulse_q |-> tif.ms == 11'h1f4)
    else $error("step playback is not 500 ms");
  gap_pulse_a: assert property (state_q == S_GROUP && adv |=>
      state_q == S_WAIT && wnext_q == S_RTPM && pulse_q)
    else $error("final gap not armed");
  usb_start_a: assert property ($rose(usw_s2_q) && !usb_q |=>
      o_usb_mode_indicator && !o_touch_enabled)
    else $error("switch press did not enter usb mode");
  usb_stay_a: assert property (usb_q |=> usb_q)
    else $error("usb mode left without reset");
  dir_reg_a: assert property (req_q && state_q == S_DIR |->
      reg_q == 8'h03 && data_q == ((mode_q == M_ALL) ? 8'h00 :
      lra_mode ? 8'h0f : 8'hf0))
    else $error("direction write malformed");
  switch_byte_a: assert property (req_q && (state_q == S_SW ||
      state_q == S_CHAN) |-> addr_q == 7'h70 && !has_reg_q)
    else $error("switch write carries register byte");
  boot_clear_a: assert property (req_q && state_q == S_BOOT |->
      addr_q == 7'h20 && reg_q == 8'h01 && data_q == 8'h00)
    else $error("boot write does not clear expander outputs");
  out_level_a: assert property (req_q && state_q == S_OUT |->
      reg_q == 8'h01 && data_q == ((mode_q == M_ALL) ? 8'hff :
      lra_mode ? 8'hf0 : 8'h0f))
    else $error("output level write malformed");
  touch_off_a: assert property (usb_q |-> !o_touch_enabled)
    else $error("buttons live in usb mode");
  busy_ignore_a: assert property (btn_press && state_q != S_IDLE |=>
      $stable(mode_q))
    else $error("press during sequence changed mode");
endmodule

/* haptic_seq_pkg.sv */
// constants, modes and states of the haptic channel sequencer
package haptic_seq_pkg;
  // --------------------------------------------------------------------
  // clock and timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int MS_W = 11;
  localparam logic [MS_W-1:0] PLAY_LONG_MS = 11'h7d0;
  localparam logic [MS_W-1:0] STEP_MS = 11'h1f4;
  localparam logic [MS_W-1:0] PULSE_MS = 11'h064;

  // --------------------------------------------------------------------
  // port expander, channel switch and haptic driver addresses
  // --------------------------------------------------------------------
  localparam logic [6:0] EXP_ADDR = 7'h20;
  localparam logic [7:0] EXP_REG_OUT = 8'h01;
  localparam logic [7:0] EXP_REG_DIR = 8'h03;
  localparam logic [7:0] EXP_OUT_RESET = 8'h00;
  localparam logic [6:0] SW_ADDR = 7'h70;
  localparam logic [6:0] DRV_ADDR = 7'h5a;
  localparam logic [7:0] DRV_REG_MODE = 8'h01;
  localparam logic [7:0] DRV_REG_RTP = 8'h02;
  localparam logic [7:0] DRV_REG_FB = 8'h1a;
  localparam logic [7:0] DRV_MODE_INT_TRIG = 8'h00;
  localparam logic [7:0] DRV_MODE_RTP = 8'h05;
  localparam logic [7:0] FB_ERM = 8'h36;
  localparam logic [7:0] FB_LRA = 8'hb6;
  localparam logic [7:0] RTP_MAG = 8'h7f;

  // --------------------------------------------------------------------
  // driver groups and demonstration modes
  // --------------------------------------------------------------------
  localparam logic [7:0] GRP_ALL = 8'hff;
  localparam logic [7:0] GRP_ERM = 8'h0f;
  localparam logic [7:0] GRP_LRA = 8'hf0;
  localparam logic [2:0] M_ALL = 3'h0;
  localparam logic [2:0] M_ERM_SIM = 3'h1;
  localparam logic [2:0] M_LRA_SIM = 3'h2;
  localparam logic [2:0] M_ERM_SEQ = 3'h3;
  localparam logic [2:0] M_LRA_SEQ = 3'h4;
  localparam logic [2:0] MODE_RESET = M_LRA_SEQ;
  localparam logic [1:0] LAST_IDX = 2'h3;

  typedef enum logic [3:0] {
    S_BOOT = 4'h0,
    S_IDLE = 4'h1,
    S_DIR = 4'h3,
    S_OUT = 4'h2,
    S_SW = 4'h6,
    S_INIT = 4'h7,
    S_RTPV = 4'h5,
    S_RTPM = 4'h4,
    S_WAIT = 4'hc,
    S_STOP = 4'hd,
    S_CHAN = 4'hf,
    S_GROUP = 4'he
  } seq_state_t;
endpackage

/* ms_timer_if.sv */
// load and done signals between the sequencer and its millisecond timer
interface ms_timer_if;
  import haptic_seq_pkg::*;
  logic load;
  logic [MS_W-1:0] ms;
  logic done;
  modport ctl (output load, output ms, input done);
  modport tmr (input load, input ms, output done);
endinterface

/* ms_timer.sv */
// millisecond tick divider and countdown timer
module ms_timer
  import haptic_seq_pkg::*;
#(
  parameter int TICK_CYCLES = MS_CYCLES
) (
  input wire logic i_core_clk, // system clock
  input wire logic i_rst,      // synchronous reset
  ms_timer_if.tmr tif          // load and done
);
  logic [31:0] div_q, div_d;
  logic [MS_W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic tick;

  assign tick = (div_q == 32'(TICK_CYCLES - 1));
  assign tif.done = done_q;

  // --------------------------------------------------------------------
  // divider restarts on load so each wait is whole milliseconds
  // --------------------------------------------------------------------
  always_comb begin
    div_d = tick ? 32'h0 : div_q + 32'h1;
    cnt_d = cnt_q;
    done_d = 1'b0;
    if (tif.load) begin
      div_d = 32'h0;
      cnt_d = tif.ms;
    end else if (tick && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1;
      done_d = (cnt_q == 11'h1);
    end
  end

  // registers of the timer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_q <= 32'h0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      div_q <= div_d;
      cnt_q <= cnt_d;
      done_q <= done_d;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  load_quiet_a: assert property (tif.load |=> !done_q)
    else $error("timer finished right after load");
  done_single_a: assert property (done_q |=> !done_q)
    else $error("timer done lasted two cycles");
endmodule

/* i2c_far_model.sv */
// behavioural i2c master answer plus expander and channel switch state
module i2c_far_model
  import haptic_seq_pkg::*;
(
  input wire logic i_core_clk,   // system clock
  input wire logic i_rst,        // synchronous reset, high
  input wire logic i_slow,       // stretch the answer to six cycles
  input wire logic i_req,        // write request
  input wire logic [6:0] i_addr, // slave address
  input wire logic i_has_reg,    // register byte present
  input wire logic [7:0] i_reg,  // register byte
  input wire logic [7:0] i_data, // data byte
  output logic o_done            // write finished pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [7:0] dir_q;
  logic [7:0] out_q;
  logic [7:0] sel_q;

  // ------------------------------------------------------------------
  // answer once per request, then apply the write to the slave state
  // ------------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      o_done <= 1'b0;
      dir_q <= 8'hff;
      out_q <= EXP_OUT_RESET;
      sel_q <= 8'h00;
    end else begin
      o_done <= 1'b0;
      cnt_q <= 4'h0;
      if (i_req && !o_done) begin
        if (cnt_q >= (i_slow ? 4'h5 : 4'h1)) begin
          o_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
      if (o_done && i_req) begin
        if (i_addr == EXP_ADDR && i_has_reg && i_reg == EXP_REG_DIR) begin
          dir_q <= i_data;
        end
        if (i_addr == EXP_ADDR && i_has_reg && i_reg == EXP_REG_OUT) begin
          out_q <= i_data;
        end
        // only the last byte counts as the channel selection
        if (i_addr == SW_ADDR) begin
          sel_q <= i_data;
        end
      end
    end
  end
endmodule

/* haptic_channel_sequencer_test.sv */
// self-checking bench for the haptic channel sequencer
module haptic_channel_sequencer_test;
  import haptic_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 2;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic btn = 1'b0;
  logic usb_sw = 1'b0;
  logic slow = 1'b0;
  logic done;
  logic req;
  logic [6:0] addr;
  logic has_reg;
  logic [7:0] i2c_reg;
  logic [7:0] data;
  logic led;
  logic touch_en;
  logic busy;
  logic [2:0] mode;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [23:0] exp_q[$];
  logic [23:0] got_q[$];
  int gap_q[$];
  int t_q[$];

  always #5 clk = ~clk;

  haptic_channel_sequencer #(.TICK_CYCLES(T)) uut (
    .i_core_clk(clk), .i_rst(rst), .i_second_touch_button(btn),
    .i_usb_entry_switch(usb_sw), .i_i2c_done(done), .o_i2c_req(req),
    .o_i2c_addr(addr), .o_i2c_has_reg(has_reg), .o_i2c_reg(i2c_reg),
    .o_i2c_data(data), .o_usb_mode_indicator(led),
    .o_touch_enabled(touch_en), .o_busy(busy), .o_mode(mode)
  );

  i2c_far_model far_side (
    .i_core_clk(clk), .i_rst(rst), .i_slow(slow), .i_req(req),
    .i_addr(addr), .i_has_reg(has_reg), .i_reg(i2c_reg), .i_data(data),
    .o_done(done)
  );

  // ------------------------------------------------------------------
  // record each finished write with its cycle, and cut a hang short
  // ------------------------------------------------------------------
  always @(negedge clk) begin
    cyc++;
    if (req === 1'b1 && done === 1'b1) begin
      got_q.push_back({has_reg, addr, i2c_reg, data});
      t_q.push_back(cyc);
    end
    if (cyc == LIMIT) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] grp(input int m);
    if (m == 0) return GRP_ALL;
    return (m % 2 == 1) ? GRP_ERM : GRP_LRA;
  endfunction

  // switch writes carry no register byte; the reg field mirrors data
  function automatic void add(input logic [6:0] a, input logic [7:0] r,
                              input logic [7:0] d, input int g);
    if (a == SW_ADDR) exp_q.push_back({1'b0, a, d, d});
    else exp_q.push_back({1'b1, a, r, d});
    gap_q.push_back(g);
  endfunction

  // expected write list of one demonstration mode
  task automatic build(input int m);
    logic [7:0] g;
    logic [7:0] fb;
    logic [7:0] ch;
    g = grp(m);
    fb = (m % 2 == 1) ? FB_ERM : FB_LRA;
    add(EXP_ADDR, EXP_REG_DIR, ~g, 0);
    add(EXP_ADDR, EXP_REG_OUT, g, 0);
    add(SW_ADDR, 8'h00, g, 0);
    if (m == 0) return;
    add(DRV_ADDR, DRV_REG_FB, fb, 0);
    add(DRV_ADDR, DRV_REG_RTP, RTP_MAG, 0);
    if (m < 3) begin
      add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_RTP, 0);
      add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_INT_TRIG, 2000);
      return;
    end
    for (int k = 0; k < 4; k++) begin
      ch = 8'h01 << ((m == 3) ? k : k + 4);
      add(SW_ADDR, 8'h00, ch, 0);
      add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_RTP, 0);
      add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_INT_TRIG, 500);
    end
    add(SW_ADDR, 8'h00, g, 0);
    add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_RTP, 100);
    add(DRV_ADDR, DRV_REG_MODE, DRV_MODE_INT_TRIG, 100);
  endtask

  task automatic press(input logic sw);
    @(posedge clk);
    if (sw) usb_sw <= 1'b1;
    else btn <= 1'b1;
    repeat (6) @(posedge clk);
    usb_sw <= 1'b0;
    btn <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic wait_busy(input logic lvl, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while (busy !== lvl && i < lim) begin
      @(negedge clk);
      i++;
    end
    check(busy, lvl);
  endtask

  // one press, a second press while busy except in mode one, then the whole write list
  task automatic run_mode(input int m);
    logic [7:0] g;
    logic [7:0] ng;
    int d;
    exp_q.delete();
    gap_q.delete();
    got_q.delete();
    t_q.delete();
    build(m);
    g = grp(m);
    ng = ~g;
    @(posedge clk);
    slow <= (m % 2 == 1);
    press(1'b0);
    wait_busy(1'b1, 100);
    if (m != 0) press(1'b0);
    wait_busy(1'b0, 12000);
    repeat (4) @(negedge clk);
    check(mode, m);
    check(got_q.size(), exp_q.size());
    for (int i = 0; i < exp_q.size(); i++) begin
      check(got_q[i], exp_q[i]);
      if (gap_q[i] != 0) begin
        d = t_q[i] - t_q[i - 1];
        check(d >= gap_q[i] * T && d <= gap_q[i] * T + 30, 1);
      end
    end
    check(far_side.dir_q, ng);
    check(far_side.out_q, g);
    check(far_side.sel_q, g);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(touch_en, 1'b1);
    check(led, 1'b0);
    check(mode, MODE_RESET);
    wait_busy(1'b0, 200);
    check(got_q.size(), 1);
    check(got_q[0], {1'b1, EXP_ADDR, EXP_REG_OUT, EXP_OUT_RESET});
    check(far_side.out_q, EXP_OUT_RESET);
    // six presses walk all five modes and wrap back to the first
    for (int m = 0; m < 6; m++) run_mode(m % 5);
    press(1'b1);
    @(negedge clk);
    check(led, 1'b1);
    check(touch_en, 1'b0);
    got_q.delete();
    press(1'b0);
    repeat (50) @(negedge clk);
    check(mode, M_ALL);
    check(got_q.size(), 0);
    check(led, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(touch_en, 1'b1);
    check(led, 1'b0);
    summarize();
  end
endmodule
